// >>> core/brt_pkg.sv
package brt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS         = 8;
  localparam int unsigned BROWNOUT_MIN_NS       = 2000;
  localparam int unsigned BROWNOUT_MIN_CYC      = (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LF_OSC_PERIOD_US      = 32;
  localparam int unsigned PUD_WIDTH             = 11;
  localparam int unsigned PUD_COUNTS            = 2048;
  localparam int unsigned POWERUP_DELAY_TIME_US = PUD_COUNTS * LF_OSC_PERIOD_US;

  // ----------------------------------------------------------------
  // configuration encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BEN_OFF   = 2'h0;
  localparam logic [1:0] BEN_SW    = 2'h1;
  localparam logic [1:0] BEN_NOSLP = 2'h2;
  localparam logic [1:0] BEN_ON    = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_WIDTH = 12;
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] CONFIG_OFS = 12'h008;

  localparam int unsigned CTRL_SWEN_BIT     = 0;
  localparam int unsigned STAT_POR_N_BIT    = 0;
  localparam int unsigned STAT_BOR_N_BIT    = 1;
  localparam int unsigned STAT_VREF_BIT     = 2;
  localparam int unsigned STAT_ACTIVE_BIT   = 3;
  localparam int unsigned STAT_HOLD_BIT     = 4;
  localparam int unsigned STAT_DELAY_BIT    = 5;
  localparam int unsigned CFG_MODE_LSB      = 0;
  localparam int unsigned CFG_LEVEL_LSB     = 2;
  localparam int unsigned CFG_PUD_DIS_N_BIT = 4;

  localparam logic RST_SWEN  = 1'b1;
  localparam logic RST_POR_N = 1'b1;
  localparam logic RST_BOR_N = 1'b1;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BRT_RUN   = 3'h1,
    BRT_HOLD  = 3'h2,
    BRT_DELAY = 3'h4
  } brt_state_t;

endpackage : brt_pkg

// >>> core/brt_low_filter.sv
`timescale 1ns/10ps
`default_nettype none

module brt_low_filter #(
  parameter int unsigned MIN_CYC = brt_pkg::BROWNOUT_MIN_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // indication
  input  wire logic enable,
  input  wire logic level,
  output logic      qualified
);
  import brt_pkg::*;

  localparam int unsigned CW = $clog2(MIN_CYC + 2);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          qual;
  } brt_flt_t;

  brt_flt_t st_reg;
  brt_flt_t st_next;

  // ----------------------------------------------------------------
  // duration counter
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (!enable || !level) begin
      st_next.cnt  = '0;
      st_next.qual = 1'b0;
    end else if (st_reg.cnt < CW'(MIN_CYC)) begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end else begin
      st_next.qual = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign qualified = st_reg.qual;

endmodule : brt_low_filter

`default_nettype wire

// >>> core/brt_sequencer.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module brt_sequencer #(
  parameter int unsigned PUD_COUNTS = brt_pkg::PUD_COUNTS,
  parameter int unsigned MIN_CYC    = brt_pkg::BROWNOUT_MIN_CYC
) (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            sys_rst,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [brt_pkg::ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // configuration word
  input  wire logic [1:0]                      brownout_enable_mode,
  input  wire logic [1:0]                      brownout_level_select,
  input  wire logic                            powerup_delay_disable_n,
  // chip inputs
  input  wire logic                            supply_low,
  input  wire logic                            power_on_event,
  input  wire logic                            sleep_mode,
  input  wire logic                            low_freq_internal_osc,
  input  wire logic                            vref_settled,
  input  wire logic                            vref_other_user,
  // chip outputs
  output logic                                 brownout_reset_hold,
  output logic                                 por_rearm,
  output logic                                 vref_enable,
  output logic [1:0]                           brownout_threshold_sel,
  output logic                                 vref_stable_flag,
  output logic                                 detect_active
);
  import brt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    brt_state_t           state;
    logic [PUD_WIDTH-1:0] pud_cnt;
    logic                 osc_prev;
    logic                 sw_en;
    logic                 por_n;
    logic                 bor_n;
    logic                 hold;
    logic                 rearm;
    logic                 vref_en;
    logic [1:0]           level;
    logic                 vref_flag;
    logic                 active;
    logic                 por_prev;
    logic                 ack;
    logic                 err;
    logic [31:0]          rdata;
  } brt_seq_t;

  brt_seq_t st_reg;
  brt_seq_t st_next;

  logic detect_enabled;
  logic detect_on;
  logic low_qualified;
  logic osc_rise;
  logic pud_done;
  logic por_start;
  logic setup_phase;
  logic wr_commit;
  logic addr_ok;
  logic sw_en_view;

  // ----------------------------------------------------------------
  // enable decode
  // ----------------------------------------------------------------
  always_comb begin
    case (brownout_enable_mode)
      BEN_OFF:   detect_enabled = 1'b0;
      BEN_SW:    detect_enabled = st_reg.sw_en;
      BEN_NOSLP: detect_enabled = !sleep_mode;
      BEN_ON:    detect_enabled = 1'b1;
      default:   detect_enabled = 1'b0;
    endcase
  end

  // software enable only counts and reads back in software mode
  assign sw_en_view = (brownout_enable_mode == BEN_SW) && st_reg.sw_en;

  // detection waits for the reference; an early disable senses nothing
  assign detect_on = detect_enabled && vref_settled;

  // ----------------------------------------------------------------
  // supply-low qualification
  // ----------------------------------------------------------------
  brt_low_filter #(
    .MIN_CYC   (MIN_CYC)
  ) u_low_filter (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .enable    (detect_on),
    .level     (supply_low),
    .qualified (low_qualified)
  );

  // ----------------------------------------------------------------
  // slow oscillator edges and power-on start
  // ----------------------------------------------------------------
  assign osc_rise  = low_freq_internal_osc && !st_reg.osc_prev;
  assign pud_done  = osc_rise && (st_reg.pud_cnt == PUD_WIDTH'(PUD_COUNTS - 1));
  assign por_start = power_on_event && !st_reg.por_prev;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_phase = psel && !penable && !st_reg.ack;
  assign wr_commit   = psel && penable && st_reg.ack && pwrite;
  assign addr_ok     = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) || (paddr == CONFIG_OFS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.osc_prev = low_freq_internal_osc;
    st_next.por_prev = power_on_event;

    // sequencer
    case (st_reg.state)
      BRT_RUN: begin
        if (power_on_event || low_qualified) begin
          st_next.state = BRT_HOLD;
        end
      end
      BRT_HOLD: begin
        // held while the supply stays low with detection enabled, or power-on is asserted
        if (!power_on_event && !(supply_low && detect_enabled)) begin
          if (!powerup_delay_disable_n) begin
            st_next.state   = BRT_DELAY;
            st_next.pud_cnt = '0;
          end else begin
            st_next.state = BRT_RUN;
          end
        end
      end
      BRT_DELAY: begin
        if (power_on_event || low_qualified) begin
          st_next.state   = BRT_HOLD;
          st_next.pud_cnt = '0;
        end else if (pud_done) begin
          st_next.state = BRT_RUN;
        end else if (osc_rise) begin
          st_next.pud_cnt = st_reg.pud_cnt + PUD_WIDTH'(1);
        end
      end
      default: begin
        st_next.state = BRT_HOLD;
      end
    endcase

    // reset hold for every non-run state, delay included
    st_next.hold = (st_next.state != BRT_RUN);

    // detector output re-arms power-on reset
    st_next.rearm = detect_on && supply_low;

    // reference request and status views
    st_next.vref_en   = detect_enabled || vref_other_user;
    st_next.level     = brownout_level_select;
    st_next.vref_flag = vref_settled;
    st_next.active    = detect_on;

    // apb answer: no wait states, data from flops
    st_next.ack = setup_phase;
    st_next.err = setup_phase && !addr_ok;
    if (setup_phase) begin
      st_next.rdata = '0;
      case (paddr)
        CTRL_OFS: begin
          st_next.rdata[CTRL_SWEN_BIT] = sw_en_view;
        end
        STATUS_OFS: begin
          st_next.rdata[STAT_POR_N_BIT]  = st_reg.por_n;
          st_next.rdata[STAT_BOR_N_BIT]  = st_reg.bor_n;
          st_next.rdata[STAT_VREF_BIT]   = st_reg.vref_flag;
          st_next.rdata[STAT_ACTIVE_BIT] = st_reg.active;
          st_next.rdata[STAT_HOLD_BIT]   = st_reg.hold;
          st_next.rdata[STAT_DELAY_BIT]  = (st_reg.state == BRT_DELAY);
        end
        CONFIG_OFS: begin
          st_next.rdata[CFG_MODE_LSB +: 2]     = brownout_enable_mode;
          st_next.rdata[CFG_LEVEL_LSB +: 2]    = brownout_level_select;
          st_next.rdata[CFG_PUD_DIS_N_BIT]     = powerup_delay_disable_n;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end

    // software writes: enable bit, and set-to-one of the por_n and bor_n status flags
    if (wr_commit && (paddr == CTRL_OFS)) begin
      st_next.sw_en = pwdata[CTRL_SWEN_BIT];
    end
    if (wr_commit && (paddr == STATUS_OFS)) begin
      if (pwdata[STAT_POR_N_BIT]) begin
        st_next.por_n = 1'b1;
      end
      if (pwdata[STAT_BOR_N_BIT]) begin
        st_next.bor_n = 1'b1;
      end
    end

    // hardware clears win over a software set in the same cycle
    if (por_start) begin
      st_next.por_n = 1'b0;
    end
    if (detect_enabled && (por_start || ((st_reg.state != BRT_HOLD) && low_qualified))) begin
      st_next.bor_n = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.state <= BRT_HOLD;
      st_reg.hold  <= 1'b1;
      st_reg.sw_en <= RST_SWEN;
      st_reg.por_n <= RST_POR_N;
      st_reg.bor_n <= RST_BOR_N;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                 = st_reg.rdata;
  assign pready                 = st_reg.ack;
  assign pslverr                = st_reg.ack && st_reg.err;
  assign brownout_reset_hold    = st_reg.hold;
  assign por_rearm              = st_reg.rearm;
  assign vref_enable            = st_reg.vref_en;
  assign brownout_threshold_sel = st_reg.level;
  assign vref_stable_flag       = st_reg.vref_flag;
  assign detect_active          = st_reg.active;

endmodule : brt_sequencer

`default_nettype wire

// >>> verif/brt_far_end.sv
`timescale 1ns/10ps
`default_nettype none

module brt_far_end #(
  parameter int unsigned HALF = 5
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // reference
  input  wire logic vref_enable,
  input  wire logic stall_vref,
  output logic      vref_settled,
  // slow oscillator
  output logic      low_freq_internal_osc
);
  int unsigned div_cnt;
  int unsigned settle_cnt;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt               <= 0;
      low_freq_internal_osc <= 1'b0;
    end else if (div_cnt == HALF - 1) begin
      div_cnt               <= 0;
      low_freq_internal_osc <= ~low_freq_internal_osc;
    end else begin
      div_cnt <= div_cnt + 1;
    end
    settle_cnt <= vref_enable ? ((settle_cnt < 4) ? settle_cnt + 1 : 4) : 0;
  end

  // settles some cycles after the request, drops at once; a stall keeps it unsettled
  assign vref_settled = (settle_cnt == 4) && !stall_vref;

endmodule : brt_far_end

`default_nettype wire

// >>> verif/brt_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module brt_checker
  import brt_pkg::*;
#(
  parameter int unsigned PUD_COUNTS = brt_pkg::PUD_COUNTS,
  parameter int unsigned MIN_CYC    = brt_pkg::BROWNOUT_MIN_CYC
) (
  // clock and reset
  input wire logic                           core_clk,
  input wire logic                           sys_rst,
  // apb
  input wire logic                           pwrite,
  input wire logic [brt_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  // chip side
  input wire logic [1:0]                     brownout_enable_mode,
  input wire logic [1:0]                     brownout_level_select,
  input wire logic                           supply_low,
  input wire logic                           sleep_mode,
  input wire logic                           vref_settled,
  input wire logic                           brownout_reset_hold,
  input wire logic                           por_rearm,
  input wire logic [1:0]                     brownout_threshold_sel,
  input wire logic                           detect_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // consecutive cycles of supply-low while detecting
  int unsigned low_cnt;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !(supply_low && detect_active)) begin
      low_cnt <= 0;
    end else if (low_cnt < MIN_CYC + 8) begin
      low_cnt <= low_cnt + 1;
    end
  end

  AST_THR_COPY: assert property (!$past(sys_rst) |-> brownout_threshold_sel == $past(brownout_level_select))
    else $error("threshold select mismatch");
  AST_OFF_IDLE: assert property ($past(brownout_enable_mode) == BEN_OFF |-> !detect_active)
    else $error("active in off mode");
  AST_ON_ACTIVE: assert property ((brownout_enable_mode == BEN_ON && vref_settled) [*3] |=> detect_active)
    else $error("inactive in on mode");
  AST_SLEEP_IDLE: assert property ((brownout_enable_mode == BEN_NOSLP && sleep_mode) [*2] |=> !detect_active)
    else $error("active in sleep");
  AST_VREF_WAIT: assert property (!vref_settled [*2] |=> !detect_active)
    else $error("active before reference settled");
  AST_SWEN_ZERO: assert property (pready && !pwrite && paddr == CTRL_OFS
    && $past(brownout_enable_mode) != BEN_SW |-> prdata[CTRL_SWEN_BIT] == 1'b0)
    else $error("software enable reads one");
  AST_REARM: assert property (por_rearm |-> $past(supply_low))
    else $error("rearm without supply low");
  AST_HOLD_KEEP: assert property (brownout_reset_hold && supply_low && detect_active |=> brownout_reset_hold)
    else $error("hold dropped while supply low");
  AST_LOW_RESETS: assert property (low_cnt >= MIN_CYC + 5 |-> brownout_reset_hold)
    else $error("long supply low without reset");

  cover property ($rose(brownout_reset_hold));
  cover property ($fell(brownout_reset_hold));
  cover property (pready && paddr == CTRL_OFS);

endmodule : brt_checker

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import brt_pkg::*;
  localparam int unsigned PC      = 4;
  localparam int unsigned OSC_PER = 10;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  brownout_enable_mode, brownout_level_select, brownout_threshold_sel;
  logic        powerup_delay_disable_n, supply_low, power_on_event, sleep_mode, stall_vref;
  logic        low_freq_internal_osc, vref_settled, vref_other_user, vref_enable;
  logic        brownout_reset_hold, por_rearm, vref_stable_flag, detect_active;
  int          err_total, n_compared, t;

  brt_sequencer #(.PUD_COUNTS(PC), .MIN_CYC(2)) brt_sequencer_inst (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .brownout_enable_mode, .brownout_level_select, .powerup_delay_disable_n, .supply_low,
    .power_on_event, .sleep_mode, .low_freq_internal_osc, .vref_settled, .vref_other_user,
    .brownout_reset_hold, .por_rearm, .vref_enable, .brownout_threshold_sel, .vref_stable_flag,
    .detect_active
  );
  brt_far_end #(.HALF(OSC_PER / 2)) brt_far_end_inst (
    .core_clk, .sys_rst, .vref_enable, .stall_vref, .vref_settled, .low_freq_internal_osc
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    cyc(1);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    cyc(1);
    penable <= 1'b1;
    // answer taken at the rising edge where pready is seen high; only the watchdog ends a wait
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // supply low for len + 1 cycles, optionally again in mid-delay; t = cycles until release
  task automatic bo(input int len, input logic relow);
    cyc(1);
    supply_low <= 1'b1;
    cyc(len);
    @(negedge core_clk);
    check(32'({brownout_reset_hold, por_rearm}), 32'h3);
    cyc(1);
    supply_low <= 1'b0;
    if (relow) begin
      cyc(2 * OSC_PER);
      supply_low <= 1'b1;
      cyc(12);
      supply_low <= 1'b0;
    end
    t = 0;
    @(negedge core_clk);
    while (brownout_reset_hold !== 1'b0 && t < 300) begin
      @(negedge core_clk);
      t++;
    end
  endtask : bo

  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_low, power_on_event, sleep_mode, vref_other_user, stall_vref} = '0;
    brownout_enable_mode    = BEN_SW;
    brownout_level_select   = 2'h2;
    powerup_delay_disable_n = 1'b1;
    err_total               = 0;
    n_compared              = 0;
    sys_rst                 = 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(rd[1:0]), 32'h3);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, CONFIG_OFS, 32'h0);
    apb(1'b0, CONFIG_OFS, 32'h0);
    check(rd, 32'h19);
    apb(1'b0, 12'h00C, 32'h0);
    check({rd[30:0], perr}, 32'h1);
    @(negedge core_clk);
    check(32'(brownout_threshold_sel), 32'h2);
    $display("test 1 done");
    for (int m = 0; m < 4; m++) begin
      cyc(1);
      brownout_enable_mode <= 2'(m);
      cyc(12);
      @(negedge core_clk);
      check(32'({detect_active, vref_stable_flag}), (m != 0) ? 32'h3 : 32'h0);
      apb(1'b0, CTRL_OFS, 32'h0);
      check(rd, (m == 1) ? 32'h1 : 32'h0);
    end
    sleep_mode           <= 1'b1;
    brownout_enable_mode <= BEN_NOSLP;
    cyc(3);
    @(negedge core_clk);
    check(32'(detect_active), 32'h0);
    cyc(1);
    sleep_mode <= 1'b0;
    cyc(12);
    @(negedge core_clk);
    check(32'(detect_active), 32'h1);
    cyc(1);
    brownout_enable_mode <= BEN_SW;
    apb(1'b1, CTRL_OFS, 32'h0);
    cyc(12);
    @(negedge core_clk);
    check(32'({detect_active, vref_enable}), 32'h0);
    cyc(1);
    vref_other_user <= 1'b1;
    cyc(3);
    @(negedge core_clk);
    check(32'({detect_active, vref_enable}), 32'h1);
    $display("test 2 done");
    cyc(1);
    brownout_enable_mode    <= BEN_ON;
    powerup_delay_disable_n <= 1'b0;
    apb(1'b1, STATUS_OFS, 32'h3);
    cyc(12);
    bo(20, 1'b0);
    check(32'(t >= (PC - 1) * OSC_PER && t <= PC * OSC_PER + 6), 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd, 32'hD);
    bo(20, 1'b1);
    check(32'(t >= (PC - 1) * OSC_PER && t <= PC * OSC_PER + 6), 32'h1);
    cyc(1);
    powerup_delay_disable_n <= 1'b1;
    bo(20, 1'b0);
    check(32'(t <= 4), 32'h1);
    apb(1'b1, STATUS_OFS, 32'h3);
    power_on_event <= 1'b1;
    cyc(3);
    power_on_event <= 1'b0;
    cyc(12);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(rd[1:0]), 32'h0);
    $display("test 3 done");
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      stall_vref           <= (k == 0);
      brownout_enable_mode <= (k == 0) ? BEN_ON : BEN_OFF;
      cyc(12);
      supply_low <= 1'b1;
      cyc(20);
      @(negedge core_clk);
      check(32'({brownout_reset_hold, detect_active}), 32'h0);
      cyc(1);
      supply_low <= 1'b0;
    end
    $display("test 4 done");
    give_verdict();
  end

endmodule : tb

bind brt_sequencer brt_checker #(.PUD_COUNTS(PUD_COUNTS), .MIN_CYC(MIN_CYC)) brt_checker_inst (
  .core_clk, .sys_rst, .pwrite, .paddr, .prdata, .pready, .brownout_enable_mode, .brownout_level_select,
  .supply_low, .sleep_mode, .vref_settled, .brownout_reset_hold, .por_rearm, .brownout_threshold_sel,
  .detect_active
);

`default_nettype wire
